// [core/gfxcfg_byte_lane.sv]
// Purpose: one byte of configuration storage with a per-bit write mask
// Assumes: write strobe and data come from the same clock domain
// Notes:   masked-off bits stay at their reset value and fold away in synthesis
`timescale 1ns/1ns
module gfxcfg_byte_lane #(
	parameter logic [7:0] RESET_VAL  = 8'h00,
	parameter logic [7:0] WRITE_MASK = 8'h00
) (
	input  wire logic       clk_sys,
	input  wire logic       rst_b,
	input  wire logic       wr_en,
	input  wire logic [7:0] wdata,
	output logic      [7:0] q
);

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			q <= RESET_VAL;
		end else if (wr_en) begin
			// read-only bits ignore the write
			q <= (wdata & WRITE_MASK) | (q & ~WRITE_MASK);
		end
	end

endmodule

// [core/gfxcfg_consts.svh]
// Purpose: offsets, field positions and fixed values of the graphics config header block
// Assumes: byte offsets within the 256-byte configuration space of the function
// Notes:   dword index is the byte offset shifted right by two
`ifndef GFXCFG_CONSTS_SVH
`define GFXCFG_CONSTS_SVH

`define GFXCFG_ROM_BASE_OFS     8'h30
`define GFXCFG_CAP_PTR_OFS      8'h34
`define GFXCFG_INT_ROUTE_OFS    8'h3C
`define GFXCFG_INT_PIN_OFS      8'h3D
`define GFXCFG_MIN_GNT_OFS      8'h3E
`define GFXCFG_MAX_LAT_OFS      8'h3F
`define GFXCFG_PM_HDR_OFS       8'hDC
`define GFXCFG_PM_CAPS_OFS      8'hDE

`define GFXCFG_ROM_BASE_RST     32'h0000_0000
`define GFXCFG_CAP_PTR_RST      8'hDC
`define GFXCFG_INT_ROUTE_RST    8'h00
`define GFXCFG_INT_PIN_RST      8'h01
`define GFXCFG_MIN_GNT_RST      8'h00
`define GFXCFG_MAX_LAT_RST      8'h00
`define GFXCFG_PM_CAPABILITY_IDENTIFIER        8'h01
`define GFXCFG_PM_NEXT_LINK     8'h00
`define GFXCFG_PM_CAPS_RST      16'h0021

`define GFXCFG_PM_WAKE_SUPPORT  5'h00
`define GFXCFG_PM_D2_SUPPORT    1'h0
`define GFXCFG_PM_D1_SUPPORT    1'h0
`define GFXCFG_PM_RSVD          3'h0
`define GFXCFG_PM_DEV_INIT      1'h1
`define GFXCFG_PM_AUX_PWR       1'h0
`define GFXCFG_PM_WAKE_CLK      1'h0
`define GFXCFG_PM_VERSION       3'h1

`define GFXCFG_LANE_RO_MASK     8'h00
`define GFXCFG_LANE_RW_MASK     8'hFF
`define GFXCFG_UNMAPPED_DATA    32'h0000_0000

`endif

// [core/gfxcfg_header.sv]
// Purpose: config header registers from ROM base to the power management capabilities
// Assumes: config requests come from logic on clk_sys, one at a time
// Notes:   answer registered on the clock edge after the one that takes the request; unmapped dwords read zero
`timescale 1ns/1ns
`include "gfxcfg_consts.svh"

// Summary of operation
// - ROM base address bits read zero always
// - ROM size mask bits read zero
// - ROM reserved and enable bits read zero
// - capability pointer byte reads DCh
// - interrupt routing byte stores writes, resets zero
// - interrupt pin byte reads 01h
// - minimum grant byte reads 00h
// - maximum latency byte reads 00h
// - capability identifier reads 01h
// - next capability link reads 00h
// - wake support field reads zero
// - D2 and D1 support bits read zero
// - device specific init bit reads one
// - aux power and wake clock read zero
// - version field reads 001b
// - reserved capability bits read zero
module gfxcfg_header
	import gfxcfg_pkg::*;
(
	input  wire logic         clk_sys,
	input  wire logic         rst_b,
	input  wire gfxcfg_req_t  cfg_req,
	output logic              cfg_ready,
	output gfxcfg_rsp_t       cfg_rsp,
	output logic        [7:0] interrupt_routing
);

	localparam logic [5:0] DW_ROM_BASE = 6'(`GFXCFG_ROM_BASE_OFS >> 2);
	localparam logic [5:0] DW_CAP_PTR  = 6'(`GFXCFG_CAP_PTR_OFS >> 2);
	localparam logic [5:0] DW_INT      = 6'(`GFXCFG_INT_ROUTE_OFS >> 2);
	localparam logic [5:0] DW_PM       = 6'(`GFXCFG_PM_HDR_OFS >> 2);
	localparam logic [1:0] LN_CAP_PTR  = 2'(`GFXCFG_CAP_PTR_OFS);
	localparam logic [1:0] LN_ROUTE    = 2'(`GFXCFG_INT_ROUTE_OFS);
	localparam logic [1:0] LN_PIN      = 2'(`GFXCFG_INT_PIN_OFS);
	localparam logic [1:0] LN_MIN_GNT  = 2'(`GFXCFG_MIN_GNT_OFS);
	localparam logic [1:0] LN_MAX_LAT  = 2'(`GFXCFG_MAX_LAT_OFS);
	localparam logic [1:0] LN_PM_HDR   = 2'(`GFXCFG_PM_HDR_OFS);
	localparam logic [1:0] LN_PM_CAPS  = 2'(`GFXCFG_PM_CAPS_OFS);

	gfxcfg_state_t     state;
	gfxcfg_state_t     next_state;
	gfxcfg_req_t       held_req;
	logic              next_hit;
	logic       [31:0] next_rdata;
	logic              int_dw_write;
	logic       [31:0] int_dw_value;

	gfxcfg_rom_base_t  rom_base;
	logic       [31:0] cap_ptr_dw;
	gfxcfg_pm_hdr_t    pm_hdr;
	gfxcfg_pm_caps_t   pm_caps;

	// fixed fields: the function has no option ROM, so nothing here is writable
	always_comb begin
		rom_base.base_addr  = 14'(`GFXCFG_ROM_BASE_RST >> 18);
		rom_base.size_mask  = 7'(`GFXCFG_ROM_BASE_RST >> 11);
		rom_base.reserved   = 10'(`GFXCFG_ROM_BASE_RST >> 1);
		rom_base.rom_enable = 1'(`GFXCFG_ROM_BASE_RST);
	end

	// bytes 35h-37h are reserved and read zero
	always_comb begin
		cap_ptr_dw = 32'h0000_0000;
		cap_ptr_dw[8*LN_CAP_PTR +: 8] = `GFXCFG_CAP_PTR_RST;
	end

	always_comb begin
		pm_hdr.next_capability_link  = `GFXCFG_PM_NEXT_LINK;
		pm_hdr.capability_identifier = `GFXCFG_PM_CAPABILITY_IDENTIFIER;
	end

	always_comb begin
		pm_caps.wake_support = `GFXCFG_PM_WAKE_SUPPORT;
		pm_caps.d2_support   = `GFXCFG_PM_D2_SUPPORT;
		pm_caps.d1_support   = `GFXCFG_PM_D1_SUPPORT;
		pm_caps.reserved     = `GFXCFG_PM_RSVD;
		pm_caps.dev_init     = `GFXCFG_PM_DEV_INIT;
		pm_caps.aux_power    = `GFXCFG_PM_AUX_PWR;
		pm_caps.wake_clock   = `GFXCFG_PM_WAKE_CLK;
		pm_caps.version      = `GFXCFG_PM_VERSION;
	end

	// write strobe reaches the interrupt dword only on the decode cycle
	assign int_dw_write = (state == GFXCFG_ST_DECODE) && held_req.write
		&& (held_req.dword == DW_INT);

	// one lane per byte of dword 3Ch; only the routing byte takes data
	genvar lane;
	generate
		for (lane = 0; lane < 4; lane++) begin : g_int_lane
			localparam logic [7:0] LANE_RST =
				(lane == LN_ROUTE)   ? `GFXCFG_INT_ROUTE_RST :
				(lane == LN_PIN)     ? `GFXCFG_INT_PIN_RST :
				(lane == LN_MIN_GNT) ? `GFXCFG_MIN_GNT_RST :
				`GFXCFG_MAX_LAT_RST;
			localparam logic [7:0] LANE_MASK =
				(lane == LN_ROUTE) ? `GFXCFG_LANE_RW_MASK : `GFXCFG_LANE_RO_MASK;
			gfxcfg_byte_lane #(
				.RESET_VAL  (LANE_RST),
				.WRITE_MASK (LANE_MASK)
			) u_lane (
				.clk_sys (clk_sys),
				.rst_b   (rst_b),
				.wr_en   (int_dw_write && held_req.byte_en[lane]),
				.wdata   (held_req.wdata[8*lane +: 8]),
				.q       (int_dw_value[8*lane +: 8])
			);
		end
	endgenerate

	// read mux and hit flag for the captured request
	always_comb begin
		next_hit   = 1'b1;
		next_rdata = `GFXCFG_UNMAPPED_DATA;
		if (held_req.dword == DW_ROM_BASE) begin
			next_rdata = rom_base;
		end else if (held_req.dword == DW_CAP_PTR) begin
			next_rdata = cap_ptr_dw;
		end else if (held_req.dword == DW_INT) begin
			next_rdata = int_dw_value;
		end else if (held_req.dword == DW_PM) begin
			next_rdata[16*LN_PM_HDR[1] +: 16]  = pm_hdr;
			next_rdata[16*LN_PM_CAPS[1] +: 16] = pm_caps;
		end else begin
			next_hit = 1'b0;
		end
		// byte lanes not enabled read as zero
		for (int b = 0; b < 4; b++) begin
			if (!held_req.byte_en[b]) begin
				next_rdata[8*b +: 8] = 8'h00;
			end
		end
	end

	always_comb begin
		next_state = state;
		case (state)
			GFXCFG_ST_IDLE: begin
				if (cfg_req.valid) begin
					next_state = GFXCFG_ST_DECODE;
				end
			end
			GFXCFG_ST_DECODE: begin
				next_state = GFXCFG_ST_REPLY;
			end
			GFXCFG_ST_REPLY: begin
				next_state = GFXCFG_ST_IDLE;
			end
			default: begin
				next_state = GFXCFG_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state <= GFXCFG_ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ready stays low while a request is in flight, so nothing is dropped
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cfg_ready <= 1'b1;
		end else begin
			cfg_ready <= (next_state == GFXCFG_ST_IDLE);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			held_req <= '0;
		end else if (state == GFXCFG_ST_IDLE && cfg_req.valid) begin
			held_req <= cfg_req;
		end
	end

	// every write completes, mapped or not, read-only or not
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cfg_rsp <= '0;
		end else if (next_state == GFXCFG_ST_REPLY) begin
			cfg_rsp.done  <= 1'b1;
			cfg_rsp.hit   <= next_hit;
			cfg_rsp.rdata <= held_req.write ? 32'h0000_0000 : next_rdata;
		end else begin
			cfg_rsp <= '0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			interrupt_routing <= `GFXCFG_INT_ROUTE_RST;
		end else begin
			interrupt_routing <= int_dw_value[8*LN_ROUTE +: 8];
		end
	end

endmodule

// [core/gfxcfg_pkg.sv]
// Purpose: types shared by the graphics config header block
// Assumes: constants live in gfxcfg_consts.svh
// Notes:   requests and answers travel as packed structs
package gfxcfg_pkg;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [5:0]  dword;
		logic [3:0]  byte_en;
		logic [31:0] wdata;
	} gfxcfg_req_t;

	typedef struct packed {
		logic        done;
		logic        hit;
		logic [31:0] rdata;
	} gfxcfg_rsp_t;

	typedef struct packed {
		logic [13:0] base_addr;
		logic [6:0]  size_mask;
		logic [9:0]  reserved;
		logic        rom_enable;
	} gfxcfg_rom_base_t;

	typedef struct packed {
		logic [7:0] next_capability_link;
		logic [7:0] capability_identifier;
	} gfxcfg_pm_hdr_t;

	typedef struct packed {
		logic [4:0] wake_support;
		logic       d2_support;
		logic       d1_support;
		logic [2:0] reserved;
		logic       dev_init;
		logic       aux_power;
		logic       wake_clock;
		logic [2:0] version;
	} gfxcfg_pm_caps_t;

	typedef enum logic [1:0] {
		GFXCFG_ST_IDLE   = 2'b00,
		GFXCFG_ST_DECODE = 2'b01,
		GFXCFG_ST_REPLY  = 2'b10
	} gfxcfg_state_t;

endpackage

// [verif/gfxcfg_header_asserts.sv]
// Purpose: port checks of the config header block
// Assumes: one request in flight at a time
// Notes:   taken request is latched, so reply checks ignore latency
`timescale 1ns/1ns
module gfxcfg_header_asserts
	import gfxcfg_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        rst_b,
	input wire gfxcfg_req_t cfg_req,
	input wire logic        cfg_ready,
	input wire gfxcfg_rsp_t cfg_rsp,
	input wire logic [7:0]  interrupt_routing
);
	logic        take;
	logic        rd;
	logic        rt_wr;
	gfxcfg_req_t last;
	logic [31:0] lmask;
	assign take = cfg_ready & cfg_req.valid;
	assign rd = cfg_rsp.done & ~last.write;
	assign rt_wr = last.write & (last.dword == 6'h0F) & last.byte_en[0];
	assign lmask = {{8{last.byte_en[3]}}, {8{last.byte_en[2]}},
		{8{last.byte_en[1]}}, {8{last.byte_en[0]}}};
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			last <= '0;
		else if (take)
			last <= cfg_req;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	a_answer_latency: assert property (take |-> ##[2:3] cfg_rsp.done)
		else $error("reply missing");
	a_done_pulse: assert property (cfg_rsp.done |=> !cfg_rsp.done)
		else $error("done held");
	a_busy_after: assert property (take |=> !cfg_ready)
		else $error("ready after take");
	a_write_quiet: assert property (cfg_rsp.done && last.write |-> cfg_rsp.rdata == 32'h0)
		else $error("write returned data");
	a_rom_zero: assert property (rd && last.dword == 6'h0C |-> cfg_rsp.hit
		&& cfg_rsp.rdata == 32'h0)
		else $error("rom base not zero");
	a_cap_pointer: assert property (rd && last.dword == 6'h0D
		|-> cfg_rsp.rdata == (32'h0000_00DC & lmask))
		else $error("cap pointer wrong");
	a_pin_bytes: assert property (rd && last.dword == 6'h0F
		|-> cfg_rsp.rdata == ({16'h0000, 8'h01, interrupt_routing} & lmask))
		else $error("dword 0F wrong");
	a_pm_words: assert property (rd && last.dword == 6'h37
		|-> cfg_rsp.rdata == (32'h0021_0001 & lmask))
		else $error("pm words wrong");
	a_route_store: assert property (cfg_rsp.done && rt_wr
		|=> interrupt_routing == last.wdata[7:0])
		else $error("routing not stored");
	a_route_hold: assert property ($changed(interrupt_routing) |-> rt_wr)
		else $error("routing moved");
	a_unmapped_zero: assert property (cfg_rsp.done && !(last.dword inside {6'h0C, 6'h0D,
		6'h0F, 6'h37}) |-> !cfg_rsp.hit && cfg_rsp.rdata == 32'h0)
		else $error("unmapped hit");
	c_write: cover property (take && cfg_req.write);
	c_route: cover property (cfg_rsp.done && rt_wr);
	c_miss: cover property (cfg_rsp.done && !cfg_rsp.hit);
endmodule

bind gfxcfg_header gfxcfg_header_asserts u_chk (.clk_sys(clk_sys), .rst_b(rst_b),
	.cfg_req(cfg_req), .cfg_ready(cfg_ready), .cfg_rsp(cfg_rsp),
	.interrupt_routing(interrupt_routing));

// [verif/gfxcfg_header_tb.sv]
// Purpose: self-checking bench of the config header block
// Assumes: inputs driven on falling edges, replies read there too
// Notes:   random writes hit every mapped dword and some random dwords, then read back
`timescale 1ns/1ns
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin err_total++; \
	$display("Error %s expected %h seen %h", nm, e, a); end end
module gfxcfg_header_tb
	import gfxcfg_pkg::*;
;
	logic        clk_sys;
	logic        rst_b;
	gfxcfg_req_t cfg_req;
	logic        cfg_ready;
	gfxcfg_rsp_t cfg_rsp;
	logic [7:0]  interrupt_routing;
	logic [32:0] expq[$];
	logic [32:0] note;
	logic [7:0]  exp_rt;
	logic [5:0]  dws[5] = '{6'h0C, 6'h0D, 6'h0F, 6'h37, 6'h00};
	logic [5:0]  dw;
	integer      seed = 70311;
	int          err_total = 0;
	int          num_checks = 0;
	gfxcfg_header dut (.clk_sys(clk_sys), .rst_b(rst_b), .cfg_req(cfg_req),
		.cfg_ready(cfg_ready), .cfg_rsp(cfg_rsp), .interrupt_routing(interrupt_routing));
	always #2 clk_sys = ~clk_sys;
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// note the answer, then hold valid over exactly one taking edge
	task automatic access(input logic w, input logic [5:0] d, input logic [3:0] be,
		input logic [31:0] wd);
		logic [31:0] full;
		int          n;
		n = 0;
		while (cfg_ready !== 1'b1 && n < 20) begin
			@(negedge clk_sys);
			n++;
		end
		if (n == 20)
			err_total++;
		case (d)
			6'h0D: full = 32'h0000_00DC;
			6'h0F: full = {16'h0000, 8'h01, exp_rt};
			6'h37: full = 32'h0021_0001;
			default: full = 32'h0;
		endcase
		full = full & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		expq.push_back({d inside {6'h0C, 6'h0D, 6'h0F, 6'h37}, w ? 32'h0 : full});
		if (w && d == 6'h0F && be[0])
			exp_rt = wd[7:0];
		cfg_req = {1'b1, w, d, be, wd};
		@(negedge clk_sys);
		cfg_req.valid = 1'b0;
	endtask
	always @(negedge clk_sys) begin
		if (rst_b && cfg_rsp.done === 1'b1) begin
			if (expq.size() == 0) begin
				err_total++;
				$display("Error reply expected none seen %h", cfg_rsp.rdata);
			end else begin
				note = expq.pop_front();
				`CHK("hit", note[32], cfg_rsp.hit)
				`CHK("rdata", note[31:0], cfg_rsp.rdata)
			end
		end
	end
	initial begin
		#20000;
		err_total++;
		give_verdict();
	end
	initial begin
		clk_sys = 1'b0;
		rst_b = 1'b0;
		cfg_req = '0;
		exp_rt = 8'h00;
		repeat (8) @(negedge clk_sys);
		rst_b = 1'b1;
		`CHK("routing", 8'h00, interrupt_routing)
		for (int i = 0; i < 5; i++)
			access(1'b0, dws[i], 4'hF, 32'h0);
		$display("test reset values done");
		for (int i = 0; i < 80; i++) begin
			dw = (i % 6 == 5) ? 6'($random(seed)) : dws[i % 4];
			access(1'b1, dw, 4'($random(seed)), $random(seed));
			access(1'b0, dw, (i % 3 == 0) ? 4'($random(seed)) : 4'hF, 32'h0);
			`CHK("routing", exp_rt, interrupt_routing)
		end
		$display("test random access done");
		access(1'b1, 6'h0F, 4'h1, 32'hFFFF_FF5A);
		repeat (4) @(negedge clk_sys);
		rst_b = 1'b0;
		exp_rt = 8'h00;
		repeat (2) @(negedge clk_sys);
		rst_b = 1'b1;
		`CHK("routing", 8'h00, interrupt_routing)
		access(1'b0, 6'h0F, 4'hF, 32'h0);
		repeat (4) @(negedge clk_sys);
		`CHK("pending", 0, expq.size())
		$display("test second reset done");
		give_verdict();
	end
endmodule
